//--- hdl/pp_pkg.sv
package pp_pkg;
  localparam logic [11:0] IDX_OUT_STAT = 12'hF54;
  localparam logic [11:0] IDX_IN_STAT = 12'hF55;
  localparam logic [11:0] IDX_ADDR_EN = 12'hF56;
  localparam logic [11:0] IDX_SEL_EN = 12'hF57;
  localparam logic [11:0] IDX_WAIT_CFG = 12'hF5C;
  localparam logic [11:0] IDX_MODE_CFG = 12'hF5D;
  localparam logic [11:0] IDX_IN1_LO = 12'hF60;
  localparam logic [11:0] IDX_IN1_HI = 12'hF61;
  localparam logic [11:0] IDX_IN2_LO = 12'hF62;
  localparam logic [11:0] IDX_IN2_HI = 12'hF63;
  localparam logic [11:0] IDX_OUT2_LO = 12'hF64;
  localparam logic [11:0] IDX_OUT2_HI = 12'hF65;
  localparam logic [11:0] IDX_CTRL = 12'hF66;
  localparam logic [11:0] IDX_ADDR_LO = 12'hF6E;
  localparam logic [11:0] IDX_ADDR_HI = 12'hF6F;
  localparam int MODE_LSB = 0;
  localparam int WIDE_BIT = 2;
  localparam int STEP_LSB = 3;
  localparam int IRQ_LSB = 5;
  localparam int BUSY_BIT = 7;
  localparam int WAIT_E_LSB = 0;
  localparam int WAIT_M_LSB = 2;
  localparam int WAIT_B_LSB = 6;
  localparam int SEL_EN_BIT = 6;
  localparam int CS_BIT = 6;
  localparam int FLAG_STICKY_BIT = 6;
  localparam int FLAG_ALL_BIT = 7;
  localparam int CSF_LSB = 6;
  localparam int ALP_BIT = 5;
  localparam int CSP_BIT = 3;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [3:0] EMPTY_RST = 4'hF;
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_ADDRESSED = 2'h1;
  localparam logic [1:0] MODE_SPLIT = 2'h2;
  localparam logic [1:0] MODE_COMBINED = 2'h3;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [1:0] STEP_BUF = 2'h3;
  localparam logic [1:0] IRQ_EVERY = 2'h1;
  localparam logic [1:0] IRQ_FOURTH = 2'h3;
  localparam logic [1:0] CSF_SELECT = 2'h2;
  typedef enum logic [1:0] {PH_IDLE, PH_BEGIN, PH_MIDDLE, PH_END} pp_phase_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } pp_apb_req_t;
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [1:0] a;
    logic [7:0] d;
  } pp_pins_t;
endpackage

//--- hdl/pp_port.sv
// Implementation choice: the APB interface to the registers.
module pp_port #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire pp_pkg::pp_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] data_pins_i,
  output logic [7:0] data_pins_o,
  output logic [7:0] data_pins_oe_n,
  input wire logic [7:0] addr_pins_i,
  output logic [7:0] addr_pins_o,
  output logic [7:0] addr_pins_oe_n,
  input wire logic select_pin_i,
  output logic select_pin_o,
  output logic select_pin_oe_n,
  input wire logic read_strobe_pin_i,
  output logic read_strobe_pin_o,
  output logic read_strobe_pin_oe_n,
  input wire logic write_strobe_pin_i,
  output logic write_strobe_pin_o,
  output logic write_strobe_pin_oe_n,
  output logic xfer_irq
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (ADDR_W != 16)
  begin : g_bad_width
    $error("pp_port serves a 16-bit APB address only");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] mode_cfg;
    logic [7:0] wait_cfg;
    logic [7:0] addr_en;
    logic [7:0] sel_en;
    logic [7:0] ctrl;
    logic [15:0] addr;
    logic [3:0][7:0] in_buf;
    logic [1:0][7:0] out2;
    logic [3:0] in_full;
    logic [3:0] out_empty;
    logic ovr;
    logic udr;
    logic ack;
    logic err;
    logic [31:0] rdata;
    pp_pkg::pp_phase_t phase;
    logic [3:0] cnt;
    logic second;
    logic is_read;
    logic [7:0] dout;
    logic [1:0] wptr;
    logic [1:0] rptr;
    pp_pkg::pp_pins_t sync1;
    pp_pkg::pp_pins_t sync2;
    pp_pkg::pp_pins_t prev;
    logic irq;
  } pp_state_t;

  pp_state_t st_reg;
  pp_state_t st_next;

  logic [1:0] mode;
  logic [1:0] step;
  logic [1:0] irq_sel;
  logic wide;
  logic master;
  logic buffered;
  logic [3:0] mid_w;
  logic [3:0] beg_w;
  logic [3:0] end_w;
  logic [3:0] used_mask;
  logic [11:0] idx;
  logic mapped;
  logic done;
  logic sw_wr;
  logic sw_rd;
  logic [7:0] in_stat;
  logic [7:0] out_stat;
  logic [7:0] ctl_rd;
  logic [7:0] byte_rd;
  logic [14:0] step_addr;
  logic slv_rd_evt;
  logic slv_wr_evt;
  logic [1:0] slv_idx;
  logic [7:0] out_byte;

  assign mode = st_reg.mode_cfg[pp_pkg::MODE_LSB +: 2];
  assign step = st_reg.mode_cfg[pp_pkg::STEP_LSB +: 2];
  assign irq_sel = st_reg.mode_cfg[pp_pkg::IRQ_LSB +: 2];
  assign wide = st_reg.mode_cfg[pp_pkg::WIDE_BIT];
  assign master = mode[1];
  assign buffered = !master && (step == pp_pkg::STEP_BUF);
  assign mid_w = st_reg.wait_cfg[pp_pkg::WAIT_M_LSB +: 4];
  // Begin and end waits only count when the middle wait is non-zero.
  assign beg_w = (mid_w != 4'h0) ? {2'h0, st_reg.wait_cfg[pp_pkg::WAIT_B_LSB +: 2]} : 4'h0;
  assign end_w = (mid_w != 4'h0) ? {2'h0, st_reg.wait_cfg[pp_pkg::WAIT_E_LSB +: 2]} : 4'h0;
  // Plain legacy slave only uses byte 0; every other mode uses all four.
  assign used_mask = (mode == pp_pkg::MODE_LEGACY && !buffered) ? 4'h1 : 4'hF;
  assign idx = apb_req.paddr[13:2];
  assign mapped = (apb_req.paddr[15:14] == 2'h0) && (apb_req.paddr[1:0] == 2'h0) &&
                  (idx inside {pp_pkg::IDX_OUT_STAT, pp_pkg::IDX_IN_STAT, pp_pkg::IDX_ADDR_EN,
                   pp_pkg::IDX_SEL_EN, pp_pkg::IDX_WAIT_CFG, pp_pkg::IDX_MODE_CFG,
                   pp_pkg::IDX_IN1_LO, pp_pkg::IDX_IN1_HI, pp_pkg::IDX_IN2_LO,
                   pp_pkg::IDX_IN2_HI, pp_pkg::IDX_OUT2_LO, pp_pkg::IDX_OUT2_HI,
                   pp_pkg::IDX_CTRL, pp_pkg::IDX_ADDR_LO, pp_pkg::IDX_ADDR_HI});
  assign done = apb_req.psel && apb_req.penable && st_reg.ack;
  assign sw_wr = done && apb_req.pwrite && mapped;
  assign sw_rd = done && !apb_req.pwrite && mapped;
  assign in_stat = {&(st_reg.in_full | ~used_mask), st_reg.ovr, 2'h0, st_reg.in_full};
  assign out_stat = {&(st_reg.out_empty | ~used_mask), st_reg.udr, 2'h0, st_reg.out_empty};
  assign ctl_rd = {(st_reg.phase != pp_pkg::PH_IDLE) && master, st_reg.mode_cfg[6:0]};
  // Bit 14 keeps its place while the rest of the address steps.
  assign step_addr = (step == pp_pkg::STEP_INC) ? {st_reg.addr[15], st_reg.addr[13:0]} + 15'h1 :
                     (step == pp_pkg::STEP_DEC) ? {st_reg.addr[15], st_reg.addr[13:0]} - 15'h1 :
                     {st_reg.addr[15], st_reg.addr[13:0]};
  // Slave strobes act on synchronised pins: reads on the leading edge, writes on the trailing.
  assign slv_rd_evt = !master && st_reg.sync2.cs && st_reg.sync2.rd &&
                      !(st_reg.prev.cs && st_reg.prev.rd);
  assign slv_wr_evt = !master && st_reg.prev.cs && st_reg.prev.wr &&
                      !(st_reg.sync2.cs && st_reg.sync2.wr);
  always_comb
  begin
    if (mode == pp_pkg::MODE_ADDRESSED)
    begin
      slv_idx = st_reg.prev.a;
    end
    else if (buffered)
    begin
      slv_idx = slv_rd_evt ? st_reg.rptr : st_reg.wptr;
    end
    else
    begin
      slv_idx = 2'h0;
    end
  end
  // Output bytes 0 and 1 share storage with the master address.
  assign out_byte = (slv_idx[1]) ? st_reg.out2[slv_idx[0]] : st_reg.addr[slv_idx[0]*8 +: 8];

  always_comb
  begin
    case (idx)
      pp_pkg::IDX_OUT_STAT: byte_rd = out_stat;
      pp_pkg::IDX_IN_STAT: byte_rd = in_stat;
      pp_pkg::IDX_ADDR_EN: byte_rd = st_reg.addr_en;
      pp_pkg::IDX_SEL_EN: byte_rd = st_reg.sel_en;
      pp_pkg::IDX_WAIT_CFG: byte_rd = st_reg.wait_cfg;
      pp_pkg::IDX_MODE_CFG: byte_rd = ctl_rd;
      pp_pkg::IDX_IN1_LO: byte_rd = st_reg.in_buf[0];
      pp_pkg::IDX_IN1_HI: byte_rd = st_reg.in_buf[1];
      pp_pkg::IDX_IN2_LO: byte_rd = st_reg.in_buf[2];
      pp_pkg::IDX_IN2_HI: byte_rd = st_reg.in_buf[3];
      pp_pkg::IDX_OUT2_LO: byte_rd = st_reg.out2[0];
      pp_pkg::IDX_OUT2_HI: byte_rd = st_reg.out2[1];
      pp_pkg::IDX_CTRL: byte_rd = st_reg.ctrl;
      pp_pkg::IDX_ADDR_LO: byte_rd = st_reg.addr[7:0];
      pp_pkg::IDX_ADDR_HI: byte_rd = st_reg.addr[15:8];
      default: byte_rd = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.irq = 1'b0;
    st_next.sync1 = '{select_pin_i, read_strobe_pin_i, write_strobe_pin_i, addr_pins_i[1:0],
                      data_pins_i};
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    // One wait state per access keeps prdata a flop without a read-data mux in the path.
    st_next.ack = apb_req.psel && apb_req.penable && !st_reg.ack;
    if (apb_req.psel && apb_req.penable && !st_reg.ack)
    begin
      st_next.rdata = {24'h0, byte_rd};
      st_next.err = !mapped;
    end
    if (sw_wr)
    begin
      case (idx)
        pp_pkg::IDX_OUT_STAT: st_next.udr = st_reg.udr & apb_req.pwdata[pp_pkg::FLAG_STICKY_BIT];
        pp_pkg::IDX_IN_STAT: st_next.ovr = st_reg.ovr & apb_req.pwdata[pp_pkg::FLAG_STICKY_BIT];
        pp_pkg::IDX_ADDR_EN: st_next.addr_en = apb_req.pwdata[7:0];
        pp_pkg::IDX_SEL_EN: st_next.sel_en = apb_req.pwdata[7:0] & 8'h40;
        pp_pkg::IDX_WAIT_CFG: st_next.wait_cfg = apb_req.pwdata[7:0];
        pp_pkg::IDX_MODE_CFG: st_next.mode_cfg = {1'b0, apb_req.pwdata[6:0]};
        pp_pkg::IDX_IN1_LO: st_next.in_buf[0] = apb_req.pwdata[7:0];
        pp_pkg::IDX_IN1_HI: st_next.in_buf[1] = apb_req.pwdata[7:0];
        pp_pkg::IDX_IN2_LO: st_next.in_buf[2] = apb_req.pwdata[7:0];
        pp_pkg::IDX_IN2_HI: st_next.in_buf[3] = apb_req.pwdata[7:0];
        pp_pkg::IDX_OUT2_LO: st_next.out2[0] = apb_req.pwdata[7:0];
        pp_pkg::IDX_OUT2_HI: st_next.out2[1] = apb_req.pwdata[7:0];
        pp_pkg::IDX_CTRL: st_next.ctrl = apb_req.pwdata[7:0] & 8'hE8;
        pp_pkg::IDX_ADDR_LO: st_next.addr[7:0] = apb_req.pwdata[7:0];
        pp_pkg::IDX_ADDR_HI: st_next.addr[15:8] = apb_req.pwdata[7:0];
        default: st_next.addr = st_reg.addr;
      endcase
      if (!master)
      begin
        for (int i = 0; i < 4; i++)
        begin
          if ((idx == pp_pkg::IDX_OUT2_LO + 12'(i) - 12'h2 && i >= 2) ||
              (idx == pp_pkg::IDX_ADDR_LO + 12'(i) && i < 2))
          begin
            st_next.out_empty[i] = 1'b0;
          end
        end
      end
    end
    if (sw_rd && (idx >= pp_pkg::IDX_IN1_LO) && (idx <= pp_pkg::IDX_IN2_HI))
    begin
      st_next.in_full[idx[1:0]] = 1'b0;
    end
    // Master engine; a data access while busy is dropped.
    case (st_reg.phase)
      pp_pkg::PH_IDLE:
      begin
        if (master && (sw_wr || sw_rd) && idx == pp_pkg::IDX_IN1_LO)
        begin
          st_next.phase = pp_pkg::PH_BEGIN;
          st_next.cnt = beg_w;
          st_next.second = 1'b0;
          st_next.is_read = sw_rd;
          st_next.dout = apb_req.pwdata[7:0];
        end
      end
      pp_pkg::PH_BEGIN:
      begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt == 4'h0)
        begin
          st_next.phase = pp_pkg::PH_MIDDLE;
          st_next.cnt = mid_w;
        end
      end
      pp_pkg::PH_MIDDLE:
      begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt == 4'h0)
        begin
          st_next.phase = pp_pkg::PH_END;
          st_next.cnt = end_w;
        end
      end
      pp_pkg::PH_END:
      begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt == 4'h0)
        begin
          if (st_reg.is_read)
          begin
            st_next.in_buf[st_reg.second] = st_reg.sync2.d;
          end
          st_next.addr = {step_addr[14], st_reg.addr[14], step_addr[13:0]};
          st_next.irq = (irq_sel == pp_pkg::IRQ_EVERY);
          if (wide && !st_reg.second)
          begin
            st_next.second = 1'b1;
            st_next.dout = st_reg.in_buf[1];
            st_next.phase = pp_pkg::PH_BEGIN;
            st_next.cnt = beg_w;
          end
          else
          begin
            st_next.second = 1'b0;
            st_next.phase = pp_pkg::PH_IDLE;
          end
        end
      end
      default: st_next.phase = pp_pkg::PH_IDLE;
    endcase
    // Slave strobes.
    if (slv_rd_evt)
    begin
      st_next.dout = out_byte;
      if (st_reg.out_empty[slv_idx])
      begin
        st_next.udr = 1'b1;
      end
      st_next.out_empty[slv_idx] = 1'b1;
      st_next.rptr = buffered ? st_reg.rptr + 2'h1 : st_reg.rptr;
      st_next.irq = (irq_sel == pp_pkg::IRQ_EVERY) ||
                    (irq_sel == pp_pkg::IRQ_FOURTH && slv_idx == 2'h3);
    end
    if (slv_wr_evt)
    begin
      if (st_reg.in_full[slv_idx])
      begin
        st_next.ovr = 1'b1;
      end
      else
      begin
        st_next.in_buf[slv_idx] = st_reg.prev.d;
      end
      st_next.in_full[slv_idx] = 1'b1;
      st_next.wptr = buffered ? st_reg.wptr + 2'h1 : st_reg.wptr;
      st_next.irq = (irq_sel == pp_pkg::IRQ_EVERY) ||
                    (irq_sel == pp_pkg::IRQ_FOURTH && slv_idx == 2'h3);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
      st_reg.out_empty <= pp_pkg::EMPTY_RST;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ack;
  assign pslverr = st_reg.ack && st_reg.err;
  assign xfer_irq = st_reg.irq;
  assign data_pins_o = st_reg.dout;
  assign data_pins_oe_n = {8{!((master && st_reg.phase != pp_pkg::PH_IDLE && !st_reg.is_read) ||
                         (!master && st_reg.sync2.cs && st_reg.sync2.rd))}};
  assign addr_pins_o = st_reg.addr[7:0];
  assign addr_pins_oe_n = ~(st_reg.addr_en & {8{master}});
  // Polarity applies only while the pin is a select line; as address bit 14 it is raw.
  assign select_pin_o = (st_reg.ctrl[pp_pkg::CSF_LSB +: 2] == pp_pkg::CSF_SELECT) ?
                        (st_reg.addr[pp_pkg::CS_BIT + 8] ~^ st_reg.ctrl[pp_pkg::CSP_BIT]) :
                        st_reg.addr[14];
  assign select_pin_oe_n = !(master && st_reg.sel_en[pp_pkg::SEL_EN_BIT]);
  assign read_strobe_pin_o = (mode == pp_pkg::MODE_COMBINED) ?
                             (st_reg.phase != pp_pkg::PH_IDLE && st_reg.is_read) :
                             (st_reg.phase == pp_pkg::PH_MIDDLE && st_reg.is_read);
  assign write_strobe_pin_o = (mode == pp_pkg::MODE_COMBINED) ?
                              (st_reg.phase == pp_pkg::PH_MIDDLE) :
                              (st_reg.phase == pp_pkg::PH_MIDDLE && !st_reg.is_read);
  assign read_strobe_pin_oe_n = !master;
  assign write_strobe_pin_oe_n = !master;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_busy_flag: assert property (ce && master && !ctl_rd[7] |->
    !read_strobe_pin_o && !write_strobe_pin_o && data_pins_oe_n == 8'hFF)
    else $error("strobe or data drive while not busy");
  chk_in_summary: assert property (in_stat[7] |-> &(st_reg.in_full | ~used_mask))
    else $error("input summary set with empty byte");
  chk_out_summary: assert property (out_stat[7] == &(st_reg.out_empty | ~used_mask))
    else $error("output summary wrong");
  chk_ovr_sticky: assert property (ce && st_reg.ovr && !sw_wr |=> st_reg.ovr)
    else $error("overrun flag dropped");
  chk_ovr_set: assert property (ce && slv_wr_evt && st_reg.in_full[slv_idx] |=> st_reg.ovr)
    else $error("overrun not flagged");
  chk_udr_set: assert property (ce && slv_rd_evt && st_reg.out_empty[slv_idx] |=> st_reg.udr)
    else $error("underrun not flagged");
  chk_rd_clears: assert property (ce && sw_rd && idx == pp_pkg::IDX_IN1_LO
    && !slv_wr_evt |=> !st_reg.in_full[0])
    else $error("software read kept full flag");
  chk_mid_len: assert property (disable iff (!arst_n || !ce)
    st_reg.phase == pp_pkg::PH_BEGIN && st_reg.cnt == 4'h0 && mid_w == 4'h7
    |=> (st_reg.phase == pp_pkg::PH_MIDDLE)[*8] ##1 st_reg.phase == pp_pkg::PH_END)
    else $error("middle wait length wrong");
  chk_no_waits: assert property (ce && mid_w == 4'h0
    && st_reg.phase == pp_pkg::PH_BEGIN |-> st_reg.cnt == 4'h0)
    else $error("begin wait applied with zero middle wait");
  chk_addr_pins: assert property (addr_pins_oe_n[5] == !(master && st_reg.addr_en[5]))
    else $error("address pin enable wrong");
  chk_bit14_hold: assert property (ce && st_reg.phase == pp_pkg::PH_END
    && st_reg.cnt == 4'h0 |=> st_reg.addr[14] == $past(st_reg.addr[14]))
    else $error("address bit 14 stepped");

  cov_master_write: cover property (st_reg.phase == pp_pkg::PH_MIDDLE && !st_reg.is_read);
  cov_wide_pair: cover property (st_reg.second && st_reg.phase == pp_pkg::PH_END);
  cov_slave_overrun: cover property (slv_wr_evt && st_reg.in_full[slv_idx]);
  cov_fourth_irq: cover property (st_reg.irq && irq_sel == pp_pkg::IRQ_FOURTH);

endmodule

//--- verification/pp_partner.sv
// ****************************************************************
// Far-side peripheral and host model
// ****************************************************************
module pp_partner (
  input wire logic clk,
  input wire logic [7:0] data_pins_o,
  input wire logic [7:0] data_pins_oe_n,
  input wire logic [7:0] addr_pins_o,
  input wire logic read_strobe_pin_o,
  input wire logic write_strobe_pin_o,
  output logic [7:0] data_i,
  output logic sel,
  output logic rd,
  output logic wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_wr = 8'h00;
  logic [7:0] last_addr = 8'h00;
  logic [7:0] last_rd = 8'h00;
  logic drv = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic w_d = 1'b0;
  logic r_d = 1'b0;
  logic o_d = 1'b0;
  int n_wr = 0;
  int strobe_len = 0;
  int drive_len = 0;
  initial
  begin
    data_i = 8'h00;
    sel = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
  end
  // Except during and one cycle after a read strobe, a released bus toggles every cycle so a stale byte can never pass for fresh data.
  always @(posedge clk)
  begin
    if (drv)
      data_i <= wdat;
    else
      data_i <= (read_strobe_pin_o === 1'b1 || r_d) ? addr_pins_o ^ 8'h5A : ~data_i;
    if (write_strobe_pin_o === 1'b1)
    begin
      last_wr <= data_pins_o;
      last_addr <= addr_pins_o;
      n_wr <= w_d ? n_wr : n_wr + 1;
      strobe_len <= w_d ? strobe_len + 1 : 1;
    end
    if (data_pins_oe_n[0] === 1'b0)
      drive_len <= o_d ? drive_len + 1 : 1;
    w_d <= write_strobe_pin_o === 1'b1;
    r_d <= read_strobe_pin_o === 1'b1;
    o_d <= data_pins_oe_n[0] === 1'b0;
  end
  task automatic host_wr(input logic [7:0] d);
    wdat = d;
    drv = 1'b1;
    sel <= 1'b1;
    wr <= 1'b1;
    repeat (3) @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    sel <= 1'b0;
    drv = 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic host_rd;
    sel <= 1'b1;
    rd <= 1'b1;
    repeat (4) @(posedge clk);
    last_rd = data_pins_o;
    rd <= 1'b0;
    sel <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

//--- verification/tb_top.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
// ****************************************************************
// Testbench
// ****************************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  pp_pkg::pp_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, xfer_irq, sel, rd, wr;
  logic [7:0] d_i, d_o, d_oe_n, a_o, a_oe_n, a, d;
  logic s_o, s_oe_n, r_o, r_oe_n, w_o, w_oe_n;
  logic [16:0] notes[$];
  logic [16:0] nt;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_irq = 0;
  always #50 clk = ~clk;
  always @(posedge clk)
    if (xfer_irq === 1'b1)
      n_irq++;
  pp_port u_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_pins_i(d_i), .data_pins_o(d_o),
    .data_pins_oe_n(d_oe_n), .addr_pins_i(8'h00), .addr_pins_o(a_o), .addr_pins_oe_n(a_oe_n),
    .select_pin_i(sel), .select_pin_o(s_o), .select_pin_oe_n(s_oe_n),
    .read_strobe_pin_i(rd), .read_strobe_pin_o(r_o), .read_strobe_pin_oe_n(r_oe_n),
    .write_strobe_pin_i(wr), .write_strobe_pin_o(w_o), .write_strobe_pin_oe_n(w_oe_n),
    .xfer_irq(xfer_irq));
  pp_partner u_ptn (.clk(clk), .data_pins_o(d_o), .data_pins_oe_n(d_oe_n), .addr_pins_o(a_o),
    .read_strobe_pin_o(r_o), .write_strobe_pin_o(w_o), .data_i(d_i), .sel(sel), .rd(rd),
    .wr(wr));
  // Reads leave a note of the expected byte, mask and error flag for the watcher.
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] v,
    input logic [7:0] m = 8'hFF, input logic e = 1'b0);
    int n;
    n = 0;
    if (!w)
      notes.push_back({e, m, v & m});
    req <= '{1'b1, 1'b0, w, {2'h0, idx, 2'h0}, {24'h0, v}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      n_mismatch++;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask
  always @(negedge clk)
    if (req.psel && req.penable && !req.pwrite && pready === 1'b1 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      `CHK({pslverr, prdata[7:0] & nt[15:8]}, {nt[16], nt[7:0]})
    end
  task automatic report_and_stop;
    n_mismatch += notes.size();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'h4905158a));
    a = 8'h10 + 8'($urandom_range(0, 208));
    d = 8'($urandom);
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(0, pp_pkg::IDX_OUT_STAT, 8'h8F);
    apb(0, pp_pkg::IDX_IN_STAT, 8'h00);
    apb(0, 12'h000, 8'h00, 8'h00, 1'b1);
    apb(1, pp_pkg::IDX_ADDR_EN, d);
    apb(0, pp_pkg::IDX_ADDR_EN, d);
    apb(1, pp_pkg::IDX_ADDR_EN, 8'hFC);
    apb(1, pp_pkg::IDX_MODE_CFG, 8'h0A);
    @(negedge clk);
    `CHK(a_oe_n, 8'h03)
    `CHK(s_oe_n, 1'b1)
    @(posedge clk);
    apb(1, pp_pkg::IDX_SEL_EN, 8'h40);
    @(negedge clk);
    `CHK(s_oe_n, 1'b0)
    @(posedge clk);
    apb(1, pp_pkg::IDX_ADDR_LO, a);
    apb(1, pp_pkg::IDX_ADDR_HI, 8'h40);
    apb(1, pp_pkg::IDX_CTRL, 8'h88);
    @(negedge clk);
    `CHK(s_o, 1'b1)
    `CHK({r_oe_n, w_oe_n}, 2'b00)
    @(posedge clk);
    apb(1, pp_pkg::IDX_WAIT_CFG, 8'hC3);
    apb(1, pp_pkg::IDX_IN1_LO, d);
    repeat (60) @(posedge clk);
    `CHK(u_ptn.last_wr, d)
    `CHK(u_ptn.last_addr, a)
    `CHK(u_ptn.drive_len, 3)
    `CHK(u_ptn.n_wr, 1)
    apb(0, pp_pkg::IDX_ADDR_LO, a + 8'h01);
    apb(1, pp_pkg::IDX_MODE_CFG, 8'h12);
    apb(1, pp_pkg::IDX_WAIT_CFG, 8'h1C);
    apb(1, pp_pkg::IDX_IN1_LO, d);
    apb(0, pp_pkg::IDX_MODE_CFG, 8'h80, 8'h80);
    repeat (60) @(posedge clk);
    `CHK(u_ptn.strobe_len, 8)
    apb(0, pp_pkg::IDX_ADDR_LO, a);
    apb(0, pp_pkg::IDX_MODE_CFG, 8'h12);
    apb(1, pp_pkg::IDX_MODE_CFG, 8'h07);
    apb(1, pp_pkg::IDX_WAIT_CFG, 8'h00);
    apb(1, pp_pkg::IDX_IN1_HI, ~d);
    apb(1, pp_pkg::IDX_IN1_LO, d);
    repeat (60) @(posedge clk);
    `CHK(u_ptn.n_wr, 4)
    `CHK(u_ptn.last_wr, ~d)
    apb(0, pp_pkg::IDX_ADDR_LO, a);
    // The capture sees the pins through two flops, so the read needs middle waits.
    apb(1, pp_pkg::IDX_WAIT_CFG, 8'h0C);
    apb(1, pp_pkg::IDX_MODE_CFG, 8'h02);
    apb(0, pp_pkg::IDX_IN1_LO, 8'h00, 8'h00);
    repeat (60) @(posedge clk);
    apb(0, pp_pkg::IDX_IN1_LO, a ^ 8'h5A);
    repeat (60) @(posedge clk);
    apb(1, pp_pkg::IDX_MODE_CFG, 8'h00);
    u_ptn.host_wr(d);
    apb(0, pp_pkg::IDX_IN_STAT, 8'h01, 8'h7F);
    u_ptn.host_wr(~d);
    apb(0, pp_pkg::IDX_IN_STAT, 8'h41, 8'h7F);
    apb(0, pp_pkg::IDX_IN1_LO, d);
    apb(0, pp_pkg::IDX_IN_STAT, 8'h40, 8'h7F);
    apb(1, pp_pkg::IDX_IN_STAT, 8'h00);
    apb(0, pp_pkg::IDX_IN_STAT, 8'h00, 8'h7F);
    apb(1, pp_pkg::IDX_ADDR_LO, a);
    apb(0, pp_pkg::IDX_OUT_STAT, 8'h0E);
    u_ptn.host_rd();
    `CHK(u_ptn.last_rd, a)
    apb(0, pp_pkg::IDX_OUT_STAT, 8'h8F);
    u_ptn.host_rd();
    apb(0, pp_pkg::IDX_OUT_STAT, 8'hCF);
    apb(1, pp_pkg::IDX_MODE_CFG, 8'h78);
    for (int i = 0; i < 4; i++)
      u_ptn.host_wr(d ^ 8'(i));
    apb(0, pp_pkg::IDX_IN_STAT, 8'h8F);
    apb(0, pp_pkg::IDX_IN2_HI, d ^ 8'h03);
    `CHK(n_irq, 1)
    report_and_stop();
  end
endmodule
